// ===== hdl/gpc_defs.svh
`ifndef GPC_DEFS_SVH
`define GPC_DEFS_SVH

// ---------------------------------------------------------------
// port geometry
// ---------------------------------------------------------------
`define GPC_WIDTH          16
`define GPC_SYNC_STAGES    2

// ---------------------------------------------------------------
// register group base offsets (each group: base, clr, set, inv)
// ---------------------------------------------------------------
`define GPC_OFF_ANALOG     8'h00
`define GPC_OFF_DIR        8'h10
`define GPC_OFF_LEVEL      8'h20
`define GPC_OFF_LATCH      8'h30
`define GPC_OFF_ODC        8'h40
`define GPC_OFF_PU         8'h50
`define GPC_OFF_PD         8'h60
`define GPC_OFF_CNCTL      8'h70
`define GPC_OFF_EN0        8'h80
`define GPC_OFF_EN1        8'h90
`define GPC_OFF_STAT       8'hA0
`define GPC_OFF_FLAG       8'hB0
`define GPC_OFF_LIMIT      8'hC0

// ---------------------------------------------------------------
// change notice control fields
// ---------------------------------------------------------------
`define GPC_CN_ON_BIT      15
`define GPC_CN_STYLE_BIT   11

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define GPC_RST_ANALOG     16'hFFFF
`define GPC_RST_DIR        16'hFFFF
`define GPC_RST_ZERO       16'h0000

`endif

// ===== hdl/gpc_pkg.sv
`include "gpc_defs.svh"

package gpc_pkg;

    // ---------------------------------------------------------------
    // alias operation selected by address bits 3:2
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        GPC_OP_BASE,
        GPC_OP_CLR,
        GPC_OP_SET,
        GPC_OP_INV
    } gpc_op_e;

    // ---------------------------------------------------------------
    // decoded bus access
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [7:0] grp;
        gpc_op_e    op;
        logic       hit;
    } gpc_acc_s;

endpackage : gpc_pkg

// ===== hdl/gpc_sync.sv
module gpc_sync
    import gpc_pkg::*;
#(
    parameter int WIDTH  = 16,
    parameter int STAGES = 2
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] stage_r [STAGES];

    // ---------------------------------------------------------------
    // flop chain; stage 0 feeds only stage 1
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_r[0] <= '0;
        end else begin
            stage_r[0] <= d_in;
        end
    end

    genvar g;
    generate
        for (g = 1; g < STAGES; g++) begin : g_stage
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage_r[g] <= '0;
                end else begin
                    stage_r[g] <= stage_r[g-1];
                end
            end
        end
    endgenerate

    assign q_out = stage_r[STAGES-1];

endmodule // gpc_sync

// ===== hdl/gpc_port.sv
// Notes on behaviour
// - alias writes clear, set or toggle one-bits only
// - alias addresses read back as zero
// - direction one is input, zero drives latch
// - direction bits reset to all ones
// - level read gives pins, level write hits latch
// - pin levels appear three clocks after change
// - open-drain pins only pull low or float
// - analog input pins read as zero
// - analog select resets to all ones
// - analog output pins still drive digital level
// - change notice works only when on bit set
// - style clear: primary enable flags mismatches
// - style set: enables pick rising/falling/both edges
// - change detection never gated by sleep state
// - status marks change since last level read
// - flags hold until software clears them
// - interrupt only from pins set as input
// - separate weak pull-up and pull-down enables
`include "gpc_defs.svh"

module gpc_port
    import gpc_pkg::*;
#(
    parameter int WIDTH = `GPC_WIDTH
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [WIDTH-1:0] pad_in,
    output logic      [WIDTH-1:0] pad_out,
    output logic      [WIDTH-1:0] pad_oe,
    output logic      [WIDTH-1:0] pull_up_enable,
    output logic      [WIDTH-1:0] pull_down_enable,
    output logic      [WIDTH-1:0] analog_select,
    output logic                  input_change_notice_irq
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic gpc_acc_s decode(input logic [7:0] addr);
        gpc_acc_s a;
        a.grp = {addr[7:4], 4'h0};
        a.op  = gpc_op_e'(addr[3:2]);
        a.hit = (addr < `GPC_OFF_LIMIT);
        return a;
    endfunction

    // outside a base write, only the one-bits of the written value touch the register
    function automatic logic [WIDTH-1:0] apply_op(input logic [WIDTH-1:0] cur,
                                                  input logic [WIDTH-1:0] val,
                                                  input gpc_op_e          op);
        logic [WIDTH-1:0] r;
        r = cur;
        unique case (op)
            GPC_OP_BASE: r = val;
            GPC_OP_CLR:  r = cur & ~val;
            GPC_OP_SET:  r = cur | val;
            GPC_OP_INV:  r = cur ^ val;
        endcase
        return r;
    endfunction

    // ---------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------
    logic [WIDTH-1:0] analog_r;
    logic [WIDTH-1:0] dir_r;
    logic [WIDTH-1:0] latch_r;
    logic [WIDTH-1:0] odc_r;
    logic [WIDTH-1:0] pu_r;
    logic [WIDTH-1:0] pd_r;
    logic             cn_on_r;
    logic             cn_style_r;
    logic [WIDTH-1:0] en0_r;
    logic [WIDTH-1:0] en1_r;
    logic [WIDTH-1:0] stat_r;
    logic [WIDTH-1:0] flag_r;
    logic [WIDTH-1:0] level_r;
    logic [WIDTH-1:0] prev_r;
    logic [WIDTH-1:0] last_read_r;
    logic [31:0]      prdata_r;
    logic             irq_r;

    logic [WIDTH-1:0] pad_sync;
    logic [WIDTH-1:0] level_view;
    logic [WIDTH-1:0] wval;
    logic [WIDTH-1:0] cn_word;
    logic [WIDTH-1:0] cn_wr_nxt;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;
    logic [WIDTH-1:0] event_set;
    logic [WIDTH-1:0] stat_set;
    logic [WIDTH-1:0] stat_nxt;
    logic [WIDTH-1:0] flag_nxt;
    gpc_acc_s         acc;
    logic             setup;
    logic             access;
    logic             wr;
    logic             level_rd;

    // ---------------------------------------------------------------
    // apb slave
    // ---------------------------------------------------------------
    assign acc      = decode(paddr);
    assign setup    = psel & ~penable;
    assign access   = psel & penable;
    assign wr       = access & pwrite & acc.hit;
    assign wval     = pwdata[WIDTH-1:0];
    assign pready   = 1'b1;
    assign pslverr  = access & ~acc.hit;
    assign prdata   = prdata_r;
    assign level_rd = access & ~pwrite & acc.hit & (acc.grp == `GPC_OFF_LEVEL) &
                      (acc.op == GPC_OP_BASE);

    function automatic logic wr_grp(input gpc_acc_s a, input logic [7:0] grp);
        return a.grp == grp;
    endfunction

    assign cn_word = ({{(WIDTH-1){1'b0}}, cn_on_r} << `GPC_CN_ON_BIT) |
                     ({{(WIDTH-1){1'b0}}, cn_style_r} << `GPC_CN_STYLE_BIT);
    assign cn_wr_nxt = apply_op(cn_word, wval, acc.op);

    // read data captured in the setup phase, so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (setup && !pwrite) begin
            prdata_r <= '0;
            if (acc.hit && acc.op == GPC_OP_BASE) begin
                unique case (acc.grp)
                    `GPC_OFF_ANALOG: prdata_r[WIDTH-1:0] <= analog_r;
                    `GPC_OFF_DIR:    prdata_r[WIDTH-1:0] <= dir_r;
                    `GPC_OFF_LEVEL:  prdata_r[WIDTH-1:0] <= level_view;
                    `GPC_OFF_LATCH:  prdata_r[WIDTH-1:0] <= latch_r;
                    `GPC_OFF_ODC:    prdata_r[WIDTH-1:0] <= odc_r;
                    `GPC_OFF_PU:     prdata_r[WIDTH-1:0] <= pu_r;
                    `GPC_OFF_PD:     prdata_r[WIDTH-1:0] <= pd_r;
                    `GPC_OFF_CNCTL:  prdata_r[WIDTH-1:0] <= cn_word;
                    `GPC_OFF_EN0:    prdata_r[WIDTH-1:0] <= en0_r;
                    `GPC_OFF_EN1:    prdata_r[WIDTH-1:0] <= en1_r;
                    `GPC_OFF_STAT:   prdata_r[WIDTH-1:0] <= stat_r;
                    `GPC_OFF_FLAG:   prdata_r[WIDTH-1:0] <= flag_r;
                    default:         prdata_r            <= '0;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // configuration registers
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_r <= `GPC_RST_ANALOG;
        end else if (wr && wr_grp(acc, `GPC_OFF_ANALOG)) begin
            analog_r <= apply_op(analog_r, wval, acc.op);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_r <= `GPC_RST_DIR;
        end else if (wr && wr_grp(acc, `GPC_OFF_DIR)) begin
            dir_r <= apply_op(dir_r, wval, acc.op);
        end
    end

    // writes to the level group land in the latch, never on the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_r <= `GPC_RST_ZERO;
        end else if (wr && (wr_grp(acc, `GPC_OFF_LATCH) || wr_grp(acc, `GPC_OFF_LEVEL))) begin
            latch_r <= apply_op(latch_r, wval, acc.op);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            odc_r <= `GPC_RST_ZERO;
        end else if (wr && wr_grp(acc, `GPC_OFF_ODC)) begin
            odc_r <= apply_op(odc_r, wval, acc.op);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pu_r <= `GPC_RST_ZERO;
        end else if (wr && wr_grp(acc, `GPC_OFF_PU)) begin
            pu_r <= apply_op(pu_r, wval, acc.op);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_r <= `GPC_RST_ZERO;
        end else if (wr && wr_grp(acc, `GPC_OFF_PD)) begin
            pd_r <= apply_op(pd_r, wval, acc.op);
        end
    end

    // only the on and style bits are implemented; the rest read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cn_on_r    <= 1'b0;
            cn_style_r <= 1'b0;
        end else if (wr && wr_grp(acc, `GPC_OFF_CNCTL)) begin
            cn_on_r    <= cn_wr_nxt[`GPC_CN_ON_BIT];
            cn_style_r <= cn_wr_nxt[`GPC_CN_STYLE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en0_r <= `GPC_RST_ZERO;
        end else if (wr && wr_grp(acc, `GPC_OFF_EN0)) begin
            en0_r <= apply_op(en0_r, wval, acc.op);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en1_r <= `GPC_RST_ZERO;
        end else if (wr && wr_grp(acc, `GPC_OFF_EN1)) begin
            en1_r <= apply_op(en1_r, wval, acc.op);
        end
    end

    // ---------------------------------------------------------------
    // pin sampling: two sync stages plus the level register
    // ---------------------------------------------------------------
    gpc_sync #(
        .WIDTH  (WIDTH),
        .STAGES (`GPC_SYNC_STAGES)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d_in    (pad_in),
        .q_out   (pad_sync)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_r <= '0;
            prev_r  <= '0;
        end else begin
            level_r <= pad_sync;
            prev_r  <= level_r;
        end
    end

    // analog inputs hide their voltage from the digital read path
    assign level_view = level_r & ~(analog_r & dir_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_read_r <= '0;
        end else if (setup && !pwrite && acc.hit && acc.op == GPC_OP_BASE &&
                     acc.grp == `GPC_OFF_LEVEL) begin
            // same edge that loads prdata_r; the copy takes level_r, so it matches what was read except on analog input pins
            last_read_r <= level_r;
        end
    end

    // ---------------------------------------------------------------
    // change notification
    // ---------------------------------------------------------------
    // detection runs from the sampled pins alone, with no sleep gate,
    // so a clock kept alive in sleep keeps events coming
    assign rise = level_r & ~prev_r;
    assign fall = ~level_r & prev_r;

    always_comb begin
        event_set = '0;
        if (cn_on_r) begin
            if (cn_style_r) begin
                event_set = (en0_r & rise) | (en1_r & fall);
            end else begin
                event_set = en0_r & (level_r ^ last_read_r);
            end
        end
    end

    assign stat_set = cn_on_r ? (level_r ^ prev_r) : '0;

    // set beats clear, so an edge in the clearing cycle survives
    always_comb begin
        stat_nxt = stat_r;
        if (level_rd) begin
            stat_nxt = '0;
        end
        if (wr && wr_grp(acc, `GPC_OFF_STAT)) begin
            stat_nxt = apply_op(stat_r, wval, acc.op);
        end
        stat_nxt = stat_nxt | stat_set;
    end

    always_comb begin
        flag_nxt = flag_r;
        if (wr && wr_grp(acc, `GPC_OFF_FLAG)) begin
            flag_nxt = apply_op(flag_r, wval, acc.op);
        end
        flag_nxt = flag_nxt | event_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= `GPC_RST_ZERO;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_r <= `GPC_RST_ZERO;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // output pins never raise the request even if a flag is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= cn_on_r & (|(flag_r & dir_r));
        end
    end

    assign input_change_notice_irq = irq_r;

    // ---------------------------------------------------------------
    // pad drive
    // ---------------------------------------------------------------
    // analog select is deliberately left out of the enable so an
    // analog peripheral can still see the driven level
    assign pad_out = latch_r & ~odc_r;
    assign pad_oe  = ~dir_r & ~(odc_r & latch_r);

    assign pull_up_enable   = pu_r;
    assign pull_down_enable = pd_r;
    assign analog_select    = analog_r;

endmodule // gpc_port

// ===== verification/gpc_pins_model.sv
module gpc_pins_model #(
    parameter int WIDTH = 16
) (
    input  wire logic             pclk,
    input  wire logic [WIDTH-1:0] pad_out,
    input  wire logic [WIDTH-1:0] pad_oe,
    input  wire logic [WIDTH-1:0] pull_up_enable,
    input  wire logic [WIDTH-1:0] pull_down_enable,
    input  wire logic [WIDTH-1:0] ext_val,
    input  wire logic [WIDTH-1:0] ext_en,
    output logic      [WIDTH-1:0] pad_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // ---------------------------------------------------------------
    // pad resolution
    // ---------------------------------------------------------------
    initial pad_in = '0;
    // an undriven pad with no pull wanders, so it must never read as stable
    always @(posedge pclk) begin
        for (int i = 0; i < WIDTH; i++) begin
            if (pad_oe[i]) begin
                pad_in[i] <= pad_out[i];
            end else if (ext_en[i]) begin
                pad_in[i] <= ext_val[i];
            end else if (pull_up_enable[i]) begin
                pad_in[i] <= 1'b1;
            end else if (pull_down_enable[i]) begin
                pad_in[i] <= 1'b0;
            end else begin
                pad_in[i] <= ~pad_in[i];
            end
        end
    end
endmodule // gpc_pins_model

// ===== verification/gpc_port_monitor.sv
`include "gpc_defs.svh"

module gpc_port_monitor #(
    parameter int WIDTH = 16
) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [7:0]       paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic [WIDTH-1:0] pad_in,
    input wire logic [WIDTH-1:0] pad_out,
    input wire logic [WIDTH-1:0] pad_oe,
    input wire logic [WIDTH-1:0] pull_up_enable,
    input wire logic [WIDTH-1:0] pull_down_enable,
    input wire logic [WIDTH-1:0] analog_select,
    input wire logic             input_change_notice_irq
);
    timeunit 1ns;
    timeprecision 100ps;
    // ---------------------------------------------------------------
    // access decode and sequences
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_acc;
    assign wr_acc = psel && penable && pwrite && pready;
    // pins settled long enough to have crossed the synchroniser
    sequence pins_quiet;
        ($stable(pad_in) && analog_select == '0) [*6];
    endsequence
    sequence level_read;
        psel && penable && !pwrite && paddr == `GPC_OFF_LEVEL;
    endsequence

    reset_values_a: assert property (
        $rose(presetn) |-> analog_select == '1 && pad_oe == '0 && !input_change_notice_irq)
        else $error("reset state of direction or analog select wrong");
    analog_base_a: assert property (
        wr_acc && paddr == `GPC_OFF_ANALOG |=> analog_select == $past(pwdata[WIDTH-1:0]))
        else $error("analog select base write not applied");
    analog_clear_a: assert property (
        wr_acc && paddr == `GPC_OFF_ANALOG + 8'h04
        |=> analog_select == ($past(analog_select) & ~$past(pwdata[WIDTH-1:0])))
        else $error("analog select clear alias wrong");
    pullup_set_a: assert property (
        wr_acc && paddr == `GPC_OFF_PU + 8'h08
        |=> pull_up_enable == ($past(pull_up_enable) | $past(pwdata[WIDTH-1:0])))
        else $error("pull-up set alias wrong");
    pulldown_inv_a: assert property (
        wr_acc && paddr == `GPC_OFF_PD + 8'h0C
        |=> pull_down_enable == ($past(pull_down_enable) ^ $past(pwdata[WIDTH-1:0])))
        else $error("pull-down invert alias wrong");
    pulls_hold_a: assert property (
        !(wr_acc && paddr[7:4] == 4'h5) |=> $stable(pull_up_enable))
        else $error("pull-up changed without a write");
    alias_read_zero_a: assert property (
        psel && penable && !pwrite && paddr[3:2] != 2'b00 |-> prdata == 32'h0000_0000)
        else $error("alias read returned data");
    level_read_a: assert property (
        pins_quiet ##0 level_read |-> prdata == 32'(pad_in))
        else $error("level read does not match settled pins");
    irq_inputs_only_a: assert property (
        $past(pad_oe) == '1 |-> !input_change_notice_irq)
        else $error("interrupt raised with every pin an output");
    bad_addr_err_a: assert property (
        psel && penable && paddr >= `GPC_OFF_LIMIT |-> pslverr && prdata == 32'h0000_0000)
        else $error("access beyond the register map not refused");
endmodule // gpc_port_monitor

bind gpc_port gpc_port_monitor #(.WIDTH(WIDTH)) gpc_port_monitor_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up_enable(pull_up_enable),
    .pull_down_enable(pull_down_enable), .analog_select(analog_select),
    .input_change_notice_irq(input_change_notice_irq));

// ===== verification/test_gpc_port.sv
`include "gpc_defs.svh"

module test_gpc_port;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] o_an = `GPC_OFF_ANALOG, o_dir = `GPC_OFF_DIR, o_lvl = `GPC_OFF_LEVEL;
    localparam logic [7:0] o_lat = `GPC_OFF_LATCH, o_odc = `GPC_OFF_ODC, o_pu = `GPC_OFF_PU;
    localparam logic [7:0] o_pd = `GPC_OFF_PD, o_cn = `GPC_OFF_CNCTL, o_en0 = `GPC_OFF_EN0;
    localparam logic [7:0] o_en1 = `GPC_OFF_EN1, o_st = `GPC_OFF_STAT, o_fl = `GPC_OFF_FLAG;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rd_e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_d;
    logic [15:0] pad_in, pad_out, pad_oe, pu, pd, an, ext_val, ext_en;
    int          error_cnt, n_checks, cyc;

    gpc_port #(.WIDTH(16)) gpc_port_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .pull_up_enable(pu), .pull_down_enable(pd), .analog_select(an),
        .input_change_notice_irq(irq));
    gpc_pins_model #(.WIDTH(16)) gpc_pins_model_i (.pclk(pclk), .pad_out(pad_out),
        .pad_oe(pad_oe), .pull_up_enable(pu), .pull_down_enable(pd), .ext_val(ext_val),
        .ext_en(ext_en), .pad_in(pad_in));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_d = prdata;
        rd_e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        apb(1'b0, a, 16'h0000);
        chk(rd_d, {16'h0000, e});
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic pin(input logic v);
        @(posedge pclk);
        ext_val[0] <= v;
        wt(8);
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset;
        rdchk(o_dir, 16'hFFFF);
        rdchk(o_an, 16'hFFFF);
        chk({16'h0000, pad_oe}, 32'h0000_0000);
    endtask
    task automatic t_alias;
        apb(1'b1, o_an, 16'h00F0);
        apb(1'b1, o_an + 8'h08, 16'h0F0F);
        rdchk(o_an, 16'h0FFF);
        apb(1'b1, o_an + 8'h04, 16'h00F0);
        rdchk(o_an, 16'h0F0F);
        apb(1'b1, o_an + 8'h0C, 16'hFFFF);
        rdchk(o_an, 16'hF0F0);
        rdchk(o_an + 8'h08, 16'h0000);
        rdchk(8'hC0, 16'h0000);
        chk({31'h0, rd_e}, 32'h0000_0001);
        apb(1'b1, o_an, 16'h0000);
    endtask
    task automatic t_pulls;
        apb(1'b1, o_pu + 8'h08, 16'h1238);
        apb(1'b1, o_pd + 8'h0C, 16'h4321);
        chk({16'h0000, pu}, 32'h0000_1238);
        chk({16'h0000, pd}, 32'h0000_4321);
        @(posedge pclk);
        ext_en <= 16'hFFF6;
        wt(8);
        rdchk(o_lvl, 16'h0008);
        @(posedge pclk);
        ext_en <= 16'hFFFF;
        apb(1'b1, o_pu + 8'h04, 16'hFFFF);
        apb(1'b1, o_pd, 16'h0000);
    endtask
    task automatic t_output;
        apb(1'b1, o_dir, 16'h0000);
        apb(1'b1, o_lvl, 16'hA5A5);
        rdchk(o_lat, 16'hA5A5);
        chk({16'h0000, pad_out}, 32'h0000_A5A5);
        chk({16'h0000, pad_oe}, 32'h0000_FFFF);
        apb(1'b1, o_odc, 16'h00FF);
        chk({16'h0000, pad_out}, 32'h0000_A500);
        chk({16'h0000, pad_oe}, 32'h0000_FF5A);
        apb(1'b1, o_an, 16'hFFFF);
        chk({16'h0000, pad_oe}, 32'h0000_FF5A);
        apb(1'b1, o_an, 16'h0000);
        apb(1'b1, o_odc, 16'h0000);
        apb(1'b1, o_lat, 16'h0000);
        apb(1'b1, o_dir, 16'hFFFF);
        wt(3);
    endtask
    task automatic t_analog_in;
        @(posedge pclk);
        ext_val <= 16'hFFFF;
        apb(1'b1, o_an, 16'hFFFF);
        wt(6);
        rdchk(o_lvl, 16'h0000);
        apb(1'b1, o_an, 16'h0000);
        wt(6);
        rdchk(o_lvl, 16'hFFFF);
        @(posedge pclk);
        ext_val <= 16'h0000;
        wt(6);
    endtask
    task automatic t_edges;
        apb(1'b1, o_cn, 16'h8800);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, o_en0, {15'h0, m[0]});
            apb(1'b1, o_en1, {15'h0, m[1]});
            apb(1'b1, o_fl, 16'h0000);
            pin(1'b1);
            rdchk(o_fl, {15'h0, m[0]});
            chk({31'h0, irq}, {31'h0, m[0]});
            apb(1'b1, o_fl, 16'h0000);
            pin(1'b0);
            rdchk(o_fl, {15'h0, m[1]});
            apb(1'b1, o_fl, 16'h0000);
        end
        apb(1'b1, o_cn, 16'h0800);
        pin(1'b1);
        rdchk(o_fl, 16'h0000);
        pin(1'b0);
        apb(1'b1, o_cn, 16'h8000);
        apb(1'b0, o_lvl, 16'h0000);
        apb(1'b1, o_st, 16'h0000);
        pin(1'b1);
        rdchk(o_fl, 16'h0001);
        rdchk(o_st, 16'h0001);
        apb(1'b1, o_fl, 16'h0000);
        wt(3);
        rdchk(o_fl, 16'h0001);
        apb(1'b0, o_lvl, 16'h0000);
        apb(1'b1, o_fl, 16'h0000);
        wt(3);
        rdchk(o_fl, 16'h0000);
        rdchk(o_st, 16'h0000);
        apb(1'b1, o_en0, 16'h0000);
        pin(1'b0);
        rdchk(o_fl, 16'h0000);
        apb(1'b1, o_cn, 16'h8800);
        apb(1'b1, o_en0, 16'h0001);
        apb(1'b1, o_en1, 16'h0000);
    endtask
    task automatic t_timing;
        apb(1'b1, o_fl, 16'h0000);
        wt(3);
        @(posedge pclk);
        ext_val[0] <= 1'b1;
        // the pad itself changes on the edge after this one
        @(posedge pclk);
        wt(4);
        chk({31'h0, irq}, 32'h0000_0000);
        wt(1);
        chk({31'h0, irq}, 32'h0000_0001);
        pin(1'b0);
        chk({31'h0, irq}, 32'h0000_0001);
        apb(1'b1, o_dir, 16'h0000);
        wt(2);
        chk({31'h0, irq}, 32'h0000_0000);
        apb(1'b1, o_dir, 16'hFFFF);
        wt(2);
        chk({31'h0, irq}, 32'h0000_0001);
        apb(1'b1, o_fl + 8'h04, 16'h0001);
        wt(2);
        chk({31'h0, irq}, 32'h0000_0000);
    endtask

    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
        ext_val = 16'h0000;
        ext_en  = 16'hFFFF;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_alias();
        t_pulls();
        t_output();
        t_analog_in();
        t_edges();
        t_timing();
        test_done();
    end
endmodule // test_gpc_port
